// ==== hdl/jlx_cfg.svh ====
`ifndef JLX_CFG_SVH
`define JLX_CFG_SVH

// full opcodes
`define JLX_OP_JMP_IND  8'h30
`define JLX_OP_MOV_RIR  8'hC7
`define JLX_OP_MOV_IRR  8'hD7
`define JLX_OP_MOV_RR   8'hE4
`define JLX_OP_MOV_RIND 8'hE5
`define JLX_OP_MOV_RIM  8'hE6
`define JLX_OP_MOV_IIM  8'hD6
`define JLX_OP_MOV_PR   8'hF5
`define JLX_OP_MOV_XLD  8'h87
`define JLX_OP_MOV_XST  8'h97
`define JLX_OP_BIT_LOAD 8'h47
`define JLX_OP_MEM_LD   8'hC3
`define JLX_OP_MEM_ST   8'hD3
`define JLX_OP_MEM_XSL  8'hE7
`define JLX_OP_MEM_XSS  8'hF7
`define JLX_OP_MEM_XLL  8'hA7
`define JLX_OP_MEM_XLS  8'hB7

// low-nibble opcodes, high nibble is a register or condition field
`define JLX_NIB_MOV_IMM  4'hC
`define JLX_NIB_MOV_RD   4'h8
`define JLX_NIB_MOV_WR   4'h9
`define JLX_NIB_JMP_COND 4'hD
`define JLX_NIB_REL_COND 4'hB

// high nibble classes of the memory byte loads
`define JLX_MEM_SO_LD   4'hE
`define JLX_MEM_SO_ST   4'hF
`define JLX_MEM_LO_LD   4'hA
`define JLX_MEM_LO_ST   4'hB

// pair field upper bits that mark direct addressing
`define JLX_DIRECT_PAIR 3'h0

// execution lengths in cpu cycles
`define JLX_CYC_JMP_T   4'h8
`define JLX_CYC_JMP_F   4'h6
`define JLX_CYC_JMP_IND 4'h8
`define JLX_CYC_REL     4'h6
`define JLX_CYC_MOV_S   4'h4
`define JLX_CYC_MOV_L   4'h6
`define JLX_CYC_BIT     4'h6
`define JLX_CYC_MEM     4'hA
`define JLX_CYC_MEM_SO  4'hC
`define JLX_CYC_MEM_LO  4'hE

`endif

// ==== hdl/jlx_pkg.sv ====
package jlx_pkg;

  typedef struct packed {
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [7:0] b4;
  } jlx_instr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        space;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } jlx_mem_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } jlx_rfw_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_JPCC, OP_JPI, OP_JREL, OP_LDIM, OP_LDRD, OP_LDWR,
    OP_LDIR, OP_LDRI, OP_E4, OP_E5, OP_E6, OP_D6, OP_F5,
    OP_IDXL, OP_IDXS
  } jlx_op_t;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_RD1   = 8'h02,
    ST_RD2   = 8'h04,
    ST_RD3   = 8'h08,
    ST_MEM   = 8'h10,
    ST_MWAIT = 8'h20,
    ST_WR    = 8'h40,
    ST_PAD   = 8'h80
  } jlx_state_t;

endpackage

// ==== hdl/jlx_addr_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module jlx_addr_unit
(
  input  wire logic [7:0]  pair_hi,
  input  wire logic [7:0]  pair_lo,
  input  wire logic [15:0] offset,
  input  wire logic        direct,
  input  wire logic [15:0] pc_next,
  input  wire logic [7:0]  disp,
  output logic      [15:0] mem_addr,
  output logic      [15:0] rel_target
);

  wire [15:0] disp_ext;
  wire [15:0] pair_base;

  // signed displacement, -128 to +127
  assign disp_ext   = {{8{disp[7]}}, disp};
  assign rel_target = pc_next + disp_ext;
  assign pair_base  = {pair_hi, pair_lo};
  assign mem_addr   = direct ? offset : pair_base + offset;

endmodule
`default_nettype wire

// ==== hdl/jlx_exec.sv ====
// Overview of operation
// - taken relative jump adds displacement to pc, else falls through
// - displacement -128..+127 added to address after the jump
// - relative jump first byte splits into condition and operation nibbles
// - no instruction in this group writes any flag
// - absolute jump loads target when true, else falls through
// - indirect jump loads pc from pair, even register high byte
// - register load copies source to destination, source untouched
// - C7 loads via indirect working register, D7 stores; 2 bytes, 4 cycles
// - 87 loads from offset plus register, 97 stores; 3 bytes, 6 cycles
// - bit load copies selected bit to bit 0 or bit 0 to selected bit
// - bit load changes only the addressed destination bit
// - memory byte load moves a byte either way, source untouched
// - pair number low bit selects program (even) or data (odd) memory
// - C3 loads via register pair, D3 stores; 2 bytes, 10 cycles
// - E7 and F7 use pair plus one-byte offset; 3 bytes, 12 cycles
// - A7 and B7 use pair plus two-byte offset low first; 14 cycles
// - long forms with pair field 0000/0001 address memory directly
// - conditional jump is three bytes, indirect jump is opcode 30
`timescale 1ns/1ns
`default_nettype none
`include "jlx_cfg.svh"
module jlx_exec
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                start,
  input  wire jlx_pkg::jlx_instr_t instr,
  input  wire logic [15:0]         instr_pc,
  input  wire logic [7:0]          wreg_base,
  input  wire logic                cond_met,
  output logic      [3:0]          cond_field,
  output logic      [7:0]          rf_raddr,
  input  wire logic [7:0]          rf_rdata,
  output jlx_pkg::jlx_rfw_t        rf_wr,
  output jlx_pkg::jlx_mem_t        mem_o,
  input  wire logic [7:0]          mem_rdata,
  output logic                     busy,
  output logic                     done,
  output logic                     pc_we,
  output logic      [15:0]         pc_val,
  output logic                     flag_we,
  output logic                     illegal
);

  function automatic logic [7:0] wreg(input logic [7:0] base,
                                      input logic [3:0] n);
    wreg = {base[7:4], n};
  endfunction

  function automatic jlx_pkg::jlx_op_t decode(input logic [7:0] op);
    unique case (op)
      `JLX_OP_JMP_IND:  decode = jlx_pkg::OP_JPI;
      `JLX_OP_MOV_RIR:  decode = jlx_pkg::OP_LDIR;
      `JLX_OP_MOV_IRR:  decode = jlx_pkg::OP_LDRI;
      `JLX_OP_MOV_RR:   decode = jlx_pkg::OP_E4;
      `JLX_OP_MOV_RIND: decode = jlx_pkg::OP_E5;
      `JLX_OP_MOV_RIM:  decode = jlx_pkg::OP_E6;
      `JLX_OP_MOV_IIM:  decode = jlx_pkg::OP_D6;
      `JLX_OP_MOV_PR:   decode = jlx_pkg::OP_F5;
      `JLX_OP_MOV_XLD:  decode = jlx_pkg::OP_IDXL;
      `JLX_OP_MOV_XST:  decode = jlx_pkg::OP_IDXS;
      `JLX_OP_BIT_LOAD: decode = jlx_pkg::OP_NONE;
      default:
        unique case (op[3:0])
          `JLX_NIB_MOV_IMM:  decode = jlx_pkg::OP_LDIM;
          `JLX_NIB_MOV_RD:   decode = jlx_pkg::OP_LDRD;
          `JLX_NIB_MOV_WR:   decode = jlx_pkg::OP_LDWR;
          `JLX_NIB_JMP_COND: decode = jlx_pkg::OP_JPCC;
          `JLX_NIB_REL_COND: decode = jlx_pkg::OP_JREL;
          default:         decode = jlx_pkg::OP_NONE;
        endcase
    endcase
  endfunction

  jlx_pkg::jlx_state_t state_reg;
  jlx_pkg::jlx_state_t state_next;
  jlx_pkg::jlx_instr_t ins_reg;
  logic [15:0]         pc_nxt_reg;
  logic                taken_reg;
  logic [3:0]          cyc_reg;
  logic [7:0]          t1_reg;
  logic [7:0]          t2_reg;
  logic [7:0]          t3_reg;
  logic                illegal_reg;

  wire                      idle = (state_reg == jlx_pkg::ST_IDLE);
  wire                      start_ok = start && idle;
  wire jlx_pkg::jlx_instr_t ci = idle ? instr : ins_reg;
  wire                      tk = idle ? cond_met : taken_reg;
  wire [3:0]                h2 = ci.b2[7:4];
  wire [3:0]                l2 = ci.b2[3:0];
  wire [3:0]                h1 = ci.b1[7:4];

  // single-bit and memory byte forms are recognised apart from decode
  wire is_bit = (ci.b1 == `JLX_OP_BIT_LOAD);
  wire is_mem = (ci.b1[3:0] == 4'h3 && (h1 == 4'hC || h1 == 4'hD)) ||
                (ci.b1[3:0] == 4'h7 && (h1 == `JLX_MEM_SO_LD ||
                 h1 == `JLX_MEM_SO_ST || h1 == `JLX_MEM_LO_LD ||
                 h1 == `JLX_MEM_LO_ST));
  wire jlx_pkg::jlx_op_t op = decode(ci.b1);

  wire m_xs    = (h1 == `JLX_MEM_SO_LD) || (h1 == `JLX_MEM_SO_ST);
  wire m_xl    = (h1 == `JLX_MEM_LO_LD) || (h1 == `JLX_MEM_LO_ST);
  wire m_store = ci.b1[4];
  wire m_dir   = m_xl && (l2[3:1] == `JLX_DIRECT_PAIR);
  wire [15:0] m_off = m_xl ? {ci.b4, ci.b3} :
                      m_xs ? {8'h00, ci.b3} : 16'h0000;

  // bit load: byte 2 holds register, bit number and direction
  wire [2:0] b_num = ci.b2[3:1];
  wire       b_dir = ci.b2[0];
  wire [2:0] b_pos = b_dir ? b_num : 3'h0;
  wire       b_val = b_dir ? t1_reg[0] : t1_reg[b_num];
  wire [7:0] b_mask = 8'h01 << b_pos;
  wire [7:0] b_data = (t2_reg & ~b_mask) | ({7'h00, b_val} << b_pos);

  logic       n1;
  logic       n2;
  logic       n3;
  logic       me;
  logic       pl;
  logic       we;
  logic [7:0] a1;
  logic [7:0] a2;
  logic [7:0] a3;
  logic [7:0] wa;
  logic [7:0] wd;
  logic [2:0] len;
  logic [3:0] nc;

  always_comb
  begin
    n1  = 1'b0;
    n2  = 1'b0;
    n3  = 1'b0;
    me  = 1'b0;
    pl  = 1'b0;
    we  = 1'b0;
    a1  = 8'h00;
    a2  = 8'h00;
    a3  = 8'h00;
    wa  = 8'h00;
    wd  = 8'h00;
    len = 3'h2;
    nc  = `JLX_CYC_MOV_S;
    if (is_bit)
    begin
      n1  = 1'b1;
      n2  = 1'b1;
      we  = 1'b1;
      len = 3'h3;
      nc  = `JLX_CYC_BIT;
      a1  = b_dir ? wreg(wreg_base, h2) : ci.b3;
      a2  = b_dir ? ci.b3 : wreg(wreg_base, h2);
      wa  = a2;
      wd  = b_data;
    end
    else if (is_mem)
    begin
      n1  = !m_dir;
      n2  = !m_dir;
      n3  = m_store;
      me  = 1'b1;
      we  = !m_store;
      len = m_xl ? 3'h4 : m_xs ? 3'h3 : 3'h2;
      nc  = m_xl ? `JLX_CYC_MEM_LO : m_xs ? `JLX_CYC_MEM_SO : `JLX_CYC_MEM;
      a1  = wreg(wreg_base, {l2[3:1], 1'b0});
      a2  = wreg(wreg_base, {l2[3:1], 1'b1});
      a3  = wreg(wreg_base, h2);
      wa  = a3;
      wd  = t3_reg;
    end
    else
      unique case (op)
        jlx_pkg::OP_JPCC:
        begin
          len = 3'h3;
          pl  = tk;
          nc  = tk ? `JLX_CYC_JMP_T : `JLX_CYC_JMP_F;
        end
        jlx_pkg::OP_JPI:
        begin
          n1 = 1'b1;
          n2 = 1'b1;
          a1 = {ci.b2[7:1], 1'b0};
          a2 = {ci.b2[7:1], 1'b1};
          pl = 1'b1;
          nc = `JLX_CYC_JMP_IND;
        end
        jlx_pkg::OP_JREL:
        begin
          pl = tk;
          nc = `JLX_CYC_REL;
        end
        jlx_pkg::OP_LDIM:
        begin
          we = 1'b1;
          wa = wreg(wreg_base, h1);
          wd = ci.b2;
        end
        jlx_pkg::OP_LDRD:
        begin
          n1 = 1'b1;
          a1 = ci.b2;
          we = 1'b1;
          wa = wreg(wreg_base, h1);
          wd = t1_reg;
        end
        jlx_pkg::OP_LDWR:
        begin
          n1 = 1'b1;
          a1 = wreg(wreg_base, h1);
          we = 1'b1;
          wa = ci.b2;
          wd = t1_reg;
        end
        jlx_pkg::OP_LDIR:
        begin
          n1 = 1'b1;
          n2 = 1'b1;
          a1 = wreg(wreg_base, l2);
          a2 = t1_reg;
          we = 1'b1;
          wa = wreg(wreg_base, h2);
          wd = t2_reg;
        end
        jlx_pkg::OP_LDRI:
        begin
          n1 = 1'b1;
          n2 = 1'b1;
          a1 = wreg(wreg_base, h2);
          a2 = wreg(wreg_base, l2);
          we = 1'b1;
          wa = t1_reg;
          wd = t2_reg;
        end
        jlx_pkg::OP_E4, jlx_pkg::OP_E5, jlx_pkg::OP_E6, jlx_pkg::OP_D6,
        jlx_pkg::OP_F5:
        begin
          len = 3'h3;
          nc  = `JLX_CYC_MOV_L;
          we  = 1'b1;
          n1  = (op != jlx_pkg::OP_E6);
          n2  = (op == jlx_pkg::OP_E5) || (op == jlx_pkg::OP_F5);
          a1  = (op == jlx_pkg::OP_F5) ? ci.b3 : ci.b2;
          a2  = (op == jlx_pkg::OP_F5) ? ci.b2 : t1_reg;
          wa  = (op == jlx_pkg::OP_E6) ? ci.b2 :
                (op == jlx_pkg::OP_E4 || op == jlx_pkg::OP_E5) ? ci.b3 :
                t1_reg;
          wd  = (op == jlx_pkg::OP_E4) ? t1_reg :
                (op == jlx_pkg::OP_E6 || op == jlx_pkg::OP_D6) ? ci.b3 :
                t2_reg;
        end
        jlx_pkg::OP_IDXL, jlx_pkg::OP_IDXS:
        begin
          len = 3'h3;
          nc  = `JLX_CYC_MOV_L;
          n1  = 1'b1;
          n2  = 1'b1;
          we  = 1'b1;
          a1  = wreg(wreg_base, l2);
          a2  = (op == jlx_pkg::OP_IDXL) ? ci.b3 + t1_reg :
                wreg(wreg_base, h2);
          wa  = (op == jlx_pkg::OP_IDXL) ? wreg(wreg_base, h2) :
                ci.b3 + t1_reg;
          wd  = t2_reg;
        end
        default:
        begin
          len = 3'h1;
        end
      endcase
  end

  wire valid_op = is_bit || is_mem || (op != jlx_pkg::OP_NONE);

  // step sequencing skips phases that the instruction does not need
  wire jlx_pkg::jlx_state_t after_mw = we ? jlx_pkg::ST_WR :
                                       jlx_pkg::ST_PAD;
  wire jlx_pkg::jlx_state_t after_rd3 = me ? jlx_pkg::ST_MEM : after_mw;
  wire jlx_pkg::jlx_state_t after_rd2 = n3 ? jlx_pkg::ST_RD3 : after_rd3;
  wire jlx_pkg::jlx_state_t after_rd1 = n2 ? jlx_pkg::ST_RD2 : after_rd2;
  wire jlx_pkg::jlx_state_t first_st = n1 ? jlx_pkg::ST_RD1 : after_rd1;

  wire [15:0] mem_addr;
  wire [15:0] rel_target;

  jlx_addr_unit u_addr
  (
    .pair_hi    (t1_reg),
    .pair_lo    (t2_reg),
    .offset     (m_off),
    .direct     (m_dir),
    .pc_next    (pc_nxt_reg),
    .disp       (ins_reg.b2),
    .mem_addr   (mem_addr),
    .rel_target (rel_target)
  );

  assign done = !idle && (cyc_reg == nc - 4'h1);

  always_comb
  begin
    unique case (state_reg)
      jlx_pkg::ST_IDLE:  state_next = (start && valid_op) ? first_st :
                                      jlx_pkg::ST_IDLE;
      jlx_pkg::ST_RD1:   state_next = after_rd1;
      jlx_pkg::ST_RD2:   state_next = after_rd2;
      jlx_pkg::ST_RD3:   state_next = after_rd3;
      jlx_pkg::ST_MEM:   state_next = jlx_pkg::ST_MWAIT;
      jlx_pkg::ST_MWAIT: state_next = after_mw;
      jlx_pkg::ST_WR:    state_next = jlx_pkg::ST_PAD;
      default:           state_next = jlx_pkg::ST_PAD;
    endcase
    if (done)
      state_next = jlx_pkg::ST_IDLE;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg   <= jlx_pkg::ST_IDLE;
      cyc_reg     <= 4'h0;
      illegal_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      cyc_reg     <= idle ? 4'h1 : cyc_reg + 4'h1;
      illegal_reg <= start_ok && !valid_op;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ins_reg    <= '0;
      pc_nxt_reg <= 16'h0000;
      taken_reg  <= 1'b0;
    end
    else if (start_ok)
    begin
      ins_reg    <= instr;
      pc_nxt_reg <= instr_pc + {13'h0000, len};
      taken_reg  <= cond_met;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      t1_reg <= 8'h00;
      t2_reg <= 8'h00;
      t3_reg <= 8'h00;
    end
    else
    begin
      if (state_reg == jlx_pkg::ST_RD1)
        t1_reg <= rf_rdata;
      if (state_reg == jlx_pkg::ST_RD2)
        t2_reg <= rf_rdata;
      if (state_reg == jlx_pkg::ST_RD3)
        t3_reg <= rf_rdata;
      else if (state_reg == jlx_pkg::ST_MWAIT && !m_store)
        t3_reg <= mem_rdata;
    end
  end

  assign cond_field = ci.b1[7:4];
  assign rf_raddr = (state_reg == jlx_pkg::ST_RD1) ? a1 :
                    (state_reg == jlx_pkg::ST_RD2) ? a2 :
                    (state_reg == jlx_pkg::ST_RD3) ? a3 : 8'h00;
  assign rf_wr.we   = (state_reg == jlx_pkg::ST_WR);
  assign rf_wr.addr = wa;
  assign rf_wr.data = wd;
  assign mem_o.req   = (state_reg == jlx_pkg::ST_MEM);
  assign mem_o.we    = m_store;
  assign mem_o.space = l2[0];
  assign mem_o.addr  = mem_addr;
  assign mem_o.wdata = t3_reg;
  assign busy    = !idle;
  assign pc_we   = done && pl;
  assign pc_val  = (ins_reg.b1 == `JLX_OP_JMP_IND) ? {t1_reg, t2_reg} :
                   (ins_reg.b1[3:0] == `JLX_NIB_REL_COND) ? rel_target :
                   {ins_reg.b2, ins_reg.b3};
  assign flag_we = 1'b0;
  assign illegal = illegal_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_flags_kept: assert property (!flag_we)
    else $error("flag write from jump or load group");
  a_jr_skip: assert property (
    start_ok && instr.b1[3:0] == `JLX_NIB_REL_COND && !cond_met
    |-> ##5 (done && !pc_we))
    else $error("untaken relative jump changed pc");
  a_jr_target: assert property (
    pc_we && ins_reg.b1[3:0] == `JLX_NIB_REL_COND
    |-> pc_val == pc_nxt_reg + {{8{ins_reg.b2[7]}}, ins_reg.b2})
    else $error("relative jump target wrong");
  a_jp_false: assert property (
    start_ok && instr.b1[3:0] == `JLX_NIB_JMP_COND && !cond_met
    |-> ##5 (done && !pc_we))
    else $error("untaken absolute jump changed pc");
  a_c7_cycles: assert property (
    start_ok && instr.b1 == `JLX_OP_MOV_RIR |-> ##3 done)
    else $error("indirect register load length wrong");
  a_idx_cycles: assert property (
    start_ok && instr.b1 == `JLX_OP_MOV_XLD |-> !done [*5] ##1 done)
    else $error("indexed load length wrong");
  a_bit_single: assert property (
    rf_wr.we && ins_reg.b1 == `JLX_OP_BIT_LOAD
    |-> $onehot0(rf_wr.data ^ t2_reg))
    else $error("bit load changed more than one bit");
  a_space_sel: assert property (
    mem_o.req |-> mem_o.space == ins_reg.b2[0])
    else $error("memory space not from pair low bit");
  a_c3_cycles: assert property (
    start_ok && instr.b1 == `JLX_OP_MEM_LD |-> ##9 done)
    else $error("pair memory load length wrong");
  a_xs_cycles: assert property (
    start_ok && instr.b1 == `JLX_OP_MEM_XSS |-> ##11 done)
    else $error("short offset store length wrong");
  a_xl_cycles: assert property (
    start_ok && instr.b1 == `JLX_OP_MEM_XLL |-> ##13 done)
    else $error("long offset load length wrong");
  a_direct_addr: assert property (
    mem_o.req && m_xl && ins_reg.b2[3:1] == `JLX_DIRECT_PAIR
    |-> mem_o.addr == {ins_reg.b4, ins_reg.b3})
    else $error("direct memory address wrong");

  c_jr_taken: cover property (pc_we &&
                              ins_reg.b1[3:0] == `JLX_NIB_REL_COND);
  c_mem_store: cover property (mem_o.req && mem_o.we);
  c_bit_load: cover property (rf_wr.we && ins_reg.b1 == `JLX_OP_BIT_LOAD);
  c_jp_ind: cover property (pc_we && ins_reg.b1 == `JLX_OP_JMP_IND);

endmodule
`default_nettype wire

// ==== verification/jlx_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module jlx_far_model
(
  input  wire logic              clk,
  input  wire logic [7:0]        rf_raddr,
  output logic      [7:0]        rf_rdata,
  input  wire jlx_pkg::jlx_rfw_t rf_wr,
  input  wire jlx_pkg::jlx_mem_t mem_o,
  output logic      [7:0]        mem_rdata
);
  logic [7:0] rf [0:255];
  logic [7:0] pm [0:65535];
  logic [7:0] dm [0:65535];
  logic       rd_vld;
  logic [7:0] rd_val;
  logic [7:0] last;
  initial
  begin
    rd_vld = 1'h0;
    last   = 8'h00;
    for (int i = 0; i < 256; i++)
      rf[i] = i[7:0];
  end
  // register file answers in the same cycle
  assign rf_rdata  = rf[rf_raddr];
  // read data only valid the cycle after req, garbage otherwise
  assign mem_rdata = rd_vld ? rd_val : ~last;
  always @(posedge clk)
  begin
    if (rf_wr.we)
      rf[rf_wr.addr] <= rf_wr.data;
    rd_vld <= mem_o.req && !mem_o.we;
    if (rd_vld)
      last <= rd_val;
    if (mem_o.req && !mem_o.we)
      rd_val <= mem_o.space ? dm[mem_o.addr] : pm[mem_o.addr];
    if (mem_o.req && mem_o.we && mem_o.space)
      dm[mem_o.addr] <= mem_o.wdata;
    if (mem_o.req && mem_o.we && !mem_o.space)
      pm[mem_o.addr] <= mem_o.wdata;
  end
endmodule
`default_nettype wire

// ==== verification/jump_and_load_instr_exec_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module jump_and_load_instr_exec_bench;
  logic                clk;
  logic                rst_n;
  logic                start;
  logic                cond_met;
  logic                busy;
  logic                done;
  logic                pc_we;
  logic                flag_we;
  logic                illegal;
  logic                pcw;
  jlx_pkg::jlx_instr_t instr;
  jlx_pkg::jlx_rfw_t   rf_wr;
  jlx_pkg::jlx_mem_t   mem_o;
  logic [15:0]         instr_pc;
  logic [15:0]         pc_val;
  logic [15:0]         pcv;
  logic [7:0]          wreg_base;
  logic [7:0]          rf_raddr;
  logic [7:0]          rf_rdata;
  logic [7:0]          mem_rdata;
  logic [3:0]          cond_field;
  int                  error_cnt;
  int                  num_checks;

  jlx_exec uut
  (
    .clk(clk), .rst_n(rst_n), .start(start), .instr(instr),
    .instr_pc(instr_pc), .wreg_base(wreg_base), .cond_met(cond_met),
    .cond_field(cond_field), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata),
    .rf_wr(rf_wr), .mem_o(mem_o), .mem_rdata(mem_rdata), .busy(busy),
    .done(done), .pc_we(pc_we), .pc_val(pc_val), .flag_we(flag_we),
    .illegal(illegal)
  );

  jlx_far_model far
  (
    .clk(clk), .rf_raddr(rf_raddr), .rf_rdata(rf_rdata),
    .rf_wr(rf_wr), .mem_o(mem_o), .mem_rdata(mem_rdata)
  );

  always #50 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // issue one instruction and count cycles until done
  task automatic run(input logic [31:0] ins, input logic [15:0] pc,
                     input logic c, input logic [15:0] n);
    logic [15:0] k;
    @(negedge clk);
    instr    = ins;
    instr_pc = pc;
    cond_met = c;
    start    = 1'h1;
    #1;
    check(cond_field, ins[31:28]);
    @(negedge clk);
    start = 1'h0;
    k = 16'h0001;
    while (done !== 1'h1 && k < 16'h0028)
    begin
      check(flag_we, 1'h0);
      @(negedge clk);
      k = k + 16'h0001;
    end
    pcw = pc_we;
    pcv = pc_val;
    if (k == 16'h0028)
    begin
      error_cnt++;
      $display("[FAIL] %0t no done", $time);
      print_verdict();
    end
    check(k, n - 16'h0001);
    @(negedge clk);
    check(busy, 1'h0);
  endtask

  task automatic pcchk(input logic t, input logic [15:0] exp);
    if (t)
    begin
      check(pcw, 1'h1);
      check(pcv, exp);
    end
    else
      check(pcw, 1'h0);
  endtask

  task automatic t_jump();
    run({8'h7B, 8'h80, 16'h0000}, 16'h1000, 1'h1, 16'h0006);
    pcchk(1'h1, 16'h0F82);
    run({8'h3B, 8'h7F, 16'h0000}, 16'hFFF0, 1'h1, 16'h0006);
    pcchk(1'h1, 16'h0071);
    run({8'h3B, 8'h7F, 16'h0000}, 16'h2000, 1'h0, 16'h0006);
    pcchk(1'h0, 16'h2002);
    run({8'h7D, 8'h10, 8'h00, 8'h00}, 16'h0400, 1'h1, 16'h0008);
    pcchk(1'h1, 16'h1000);
    run({8'h7D, 8'h10, 8'h00, 8'h00}, 16'h0400, 1'h0, 16'h0006);
    pcchk(1'h0, 16'h0403);
    far.rf[8'h20] = 8'h01;
    far.rf[8'h21] = 8'h20;
    run({8'h30, 8'h20, 16'h0000}, 16'h0500, 1'h0, 16'h0008);
    pcchk(1'h1, 16'h0120);
    $display("test jumps done");
  endtask

  task automatic t_load();
    far.rf[8'hC2] = 8'h40;
    far.rf[8'h40] = 8'h5A;
    run({8'hC7, 8'h12, 16'h0000}, 16'h0100, 1'h0, 16'h0004);
    check(far.rf[8'hC1], 8'h5A);
    check(far.rf[8'hC2], 8'h40);
    far.rf[8'hC3] = 8'h3C;
    run({8'hD7, 8'h23, 16'h0000}, 16'h0100, 1'h0, 16'h0004);
    check(far.rf[8'h40], 8'h3C);
    run({8'h87, 8'h43, 8'h04, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'hC4], 8'h3C);
    run({8'h97, 8'h13, 8'h05, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'h41], 8'h5A);
    check(far.rf[8'hC1], 8'h5A);
    run({8'h7C, 8'hA5, 16'h0000}, 16'h0100, 1'h0, 16'h0004);
    check(far.rf[8'hC7], 8'hA5);
    run({8'hE6, 8'h60, 8'h99, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'h60], 8'h99);
    run({8'hE4, 8'h60, 8'h61, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'h61], 8'h99);
    run({8'h68, 8'h61, 16'h0000}, 16'h0100, 1'h0, 16'h0004);
    check(far.rf[8'hC6], 8'h99);
    run({8'h69, 8'h62, 16'h0000}, 16'h0100, 1'h0, 16'h0004);
    check(far.rf[8'h62], 8'h99);
    run({8'hF5, 8'h61, 8'h63, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'h63], 8'h99);
    far.rf[8'h64] = 8'h6A;
    run({8'hD6, 8'h64, 8'h5C, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'h6A], 8'h5C);
    $display("test register loads done");
  endtask

  task automatic t_bit();
    far.rf[8'hC5] = 8'h06;
    far.rf[8'h50] = 8'h05;
    run({8'h47, 8'h54, 8'h50, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'hC5], 8'h07);
    check(far.rf[8'h50], 8'h05);
    run({8'h47, 8'h57, 8'h50, 8'h00}, 16'h0100, 1'h0, 16'h0006);
    check(far.rf[8'h50], 8'h0D);
    check(far.rf[8'hC5], 8'h07);
    $display("test bit loads done");
  endtask

  task automatic t_mem();
    far.rf[8'hC8] = 8'h12;
    far.rf[8'hC9] = 8'h34;
    far.pm[16'h1234] = 8'h77;
    far.dm[16'h1234] = 8'h88;
    run({8'hC3, 8'hA8, 16'h0000}, 16'h0100, 1'h0, 16'h000A);
    check(far.rf[8'hCA], 8'h77);
    run({8'hC3, 8'hB9, 16'h0000}, 16'h0100, 1'h0, 16'h000A);
    check(far.rf[8'hCB], 8'h88);
    check(far.rf[8'hC8], 8'h12);
    far.rf[8'hCC] = 8'hE1;
    run({8'hD3, 8'hC9, 16'h0000}, 16'h0100, 1'h0, 16'h000A);
    check(far.dm[16'h1234], 8'hE1);
    check(far.pm[16'h1234], 8'h77);
    check(far.rf[8'hCC], 8'hE1);
    $display("test pair memory loads done");
  endtask

  task automatic t_memx();
    far.pm[16'h1333] = 8'h66;
    far.pm[16'h2236] = 8'h44;
    far.dm[16'h1104] = 8'h98;
    far.rf[8'hCD]    = 8'h3B;
    run({8'hE7, 8'hA8, 8'hFF, 8'h00}, 16'h0100, 1'h0, 16'h000C);
    check(far.rf[8'hCA], 8'h66);
    run({8'hF7, 8'hD9, 8'h01, 8'h00}, 16'h0100, 1'h0, 16'h000C);
    check(far.dm[16'h1235], 8'h3B);
    run({8'hA7, 8'hA8, 8'h02, 8'h10}, 16'h0100, 1'h0, 16'h000E);
    check(far.rf[8'hCA], 8'h44);
    // pairs 0 and 1 act as direct address selectors only in the long offset forms
    run({8'hA7, 8'hB1, 8'h04, 8'h11}, 16'h0100, 1'h0, 16'h000E);
    check(far.rf[8'hCB], 8'h98);
    run({8'hB7, 8'hD0, 8'h05, 8'h11}, 16'h0100, 1'h0, 16'h000E);
    check(far.pm[16'h1105], 8'h3B);
    $display("test offset memory loads done");
  endtask

  task automatic t_bad();
    @(negedge clk);
    instr = {8'hFF, 24'h00_0000};
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
    check(illegal, 1'h1);
    check(busy, 1'h0);
    @(negedge clk);
    check(illegal, 1'h0);
    $display("test unknown opcode done");
  endtask

  initial
  begin
    clk        = 1'h0;
    rst_n      = 1'h0;
    start      = 1'h0;
    cond_met   = 1'h0;
    instr      = '0;
    instr_pc   = 16'h0000;
    wreg_base  = 8'hC0;
    error_cnt  = 0;
    num_checks = 0;
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    check(busy, 1'h0);
    t_jump();
    t_load();
    t_bit();
    t_mem();
    t_memx();
    t_bad();
    print_verdict();
  end
endmodule
`default_nettype wire
